// *** hw/lfm_map.svh ***
// register map, field positions, reset values and timing constants of the fault manager
`ifndef LFM_MAP_SVH
`define LFM_MAP_SVH

// byte offsets of the register words
`define LFM_OFS_STATUS_REG_ONE    8'h00
`define LFM_OFS_STATUS_REG_TWO    8'h04
`define LFM_OFS_STATUS_REG_THREE    8'h08
`define LFM_OFS_SYSTEM_CONFIG_ONE    8'h0c
`define LFM_OFS_SYSTEM_CONFIG_TWO    8'h10
`define LFM_OFS_WDTAP      8'h14
`define LFM_OFS_STATE      8'h18

// status_reg_three bit positions
`define LFM_ST3_TW         0
`define LFM_ST3_PC         1
`define LFM_ST3_SPE        2
`define LFM_ST3_V5A        3

// system_config_one positions (channel enables sit at bits 1:0)
`define LFM_CFG1_WDEN      2
`define LFM_CFG1_FPREL     3

// system_config_two positions (latch selects are 2-bit channel pairs)
`define LFM_CFG2_TS_LO     0
`define LFM_CFG2_HS_LO     2
`define LFM_CFG2_LS_LO     4
`define LFM_CFG2_IFT_LO    6
`define LFM_CFG2_PC        8

// reset values
`define LFM_ST1_RST        8'h00
`define LFM_ST2_RST        6'h00
`define LFM_ST3_RST        4'h2
`define LFM_CFG1_RST       4'h4
`define LFM_CFG2_RST       9'h000
`define LFM_WDTAP_RST      5'h18

// watchdog counter size, highest legal tap
`define LFM_WD_WIDTH       25
`define LFM_WD_TAP_MAX     5'h18

// clock rate and shortest fault retry time
`define LFM_CLK_MHZ        250
`define LFM_RETRY_BASE_US  3600

`endif

// *** hw/lfm_pkg.sv ***
// types shared by the fault manager files
package lfm_pkg;

  // per-channel protection state
  typedef enum logic [2:0] {
    LFM_OFF   = 3'b000,
    LFM_RUN   = 3'b001,
    LFM_RETRY = 3'b010,
    LFM_THERM = 3'b011,
    LFM_LATCH = 3'b100
  } lfm_chan_e;

endpackage

// *** hw/lfm_retry_timer.sv ***
// per-channel current limit fault retry timer
`timescale 1ns/1ps
`include "lfm_map.svh"

module lfm_retry_timer
  import lfm_pkg::*;
#(
  parameter int unsigned BASE_CYC = `LFM_RETRY_BASE_US * `LFM_CLK_MHZ,
  parameter int unsigned CNT_W    = 24
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic [1:0] sel,
  output logic            done
);

  logic [CNT_W-1:0] cnt_r;
  logic             busy_r;
  logic [CNT_W-1:0] load_val;

  // duration doubles per select step: base, 2x, 4x, 8x
  assign load_val = CNT_W'(BASE_CYC) << sel;

  // down counter, restarted by each start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r  <= load_val - CNT_W'(1);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r == '0) begin
          busy_r <= 1'b0;
          done   <= 1'b1;
        end else begin
          cnt_r <= cnt_r - CNT_W'(1);
        end
      end
    end
  end

endmodule // lfm_retry_timer

// *** hw/lfm_fault_mgr.sv ***
// dual-channel led driver fault manager with apb register access
`timescale 1ns/1ps
`include "lfm_map.svh"

module lfm_fault_mgr
  import lfm_pkg::*;
#(
  parameter int unsigned NCH       = 2,
  parameter int unsigned RETRY_CYC = `LFM_RETRY_BASE_US * `LFM_CLK_MHZ
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic                pready,
  output logic [31:0]         prdata,
  output logic                pslverr,
  input  wire logic [NCH-1:0] short_cmp,
  input  wire logic [NCH-1:0] hs_overcurrent,
  input  wire logic [NCH-1:0] ls_overcurrent,
  input  wire logic [NCH-1:0] toff_min_hit,
  input  wire logic [NCH-1:0] over_temp,
  input  wire logic [NCH-1:0] temp_cooled,
  input  wire logic [NCH-1:0] bootstrap_low,
  input  wire logic [NCH-1:0] loop_filter_high,
  input  wire logic           thermal_warn,
  input  wire logic           analog_supply_low,
  input  wire logic           power_cycle_evt,
  input  wire logic           serial_frame_ok,
  input  wire logic           serial_frame_err,
  output logic [NCH-1:0]      hs_gate_en,
  output logic [NCH-1:0]      ls_gate_en,
  output logic [NCH-1:0]      comp_discharge,
  output logic [NCH-1:0]      comp_disconnect,
  output logic [NCH-1:0]      soft_start,
  output logic                standalone_mode,
  output logic                fault_output_pin_o,
  output logic                fault_output_pin_oe
);

  // sticky status words
  logic [4*NCH-1:0]   status_reg_one_r;
  logic [3*NCH-1:0]   status_reg_two_r;
  logic [3:0]         status_reg_three_r;
  // configuration words
  logic [NCH+1:0]     system_config_one_r;
  logic [3*NCH+2:0]   system_config_two_r;
  logic [4:0]         watchdog_tap_select_r;
  // watchdog
  logic [`LFM_WD_WIDTH-1:0] wd_cnt_r;
  logic               wd_expire;
  // bus decode
  logic               setup_ph;
  logic               wr_done;
  logic               rd_done;
  logic               addr_ok;
  logic [31:0]        rd_mux;
  // per-channel controls
  lfm_chan_e          chan_r   [NCH];
  lfm_chan_e          chan_nxt [NCH];
  logic [NCH-1:0]     kind_hs_r;
  logic [NCH-1:0]     latch_go;
  logic [NCH-1:0]     retry_go;
  logic [NCH-1:0]     retry_done;
  logic [NCH-1:0]     en_rise;
  logic [NCH-1:0]     chan_held;
  logic [NCH-1:0]     ts_latch;
  logic [NCH-1:0]     hs_latch;
  logic [NCH-1:0]     ls_latch;
  logic               pc_latch;
  logic [1:0]         ift_sel;
  logic               any_fault;
  logic               pin_low_r;
  logic               pin_event;
  logic               serial_err_evt;
  logic [4*NCH-1:0]   st1_src;
  logic [3*NCH-1:0]   st2_src;

  // sticky flag update: the set wins over a read clear
  function automatic logic flag_upd(input logic cur, input logic ev,
                                    input logic cond, input logic clr);
    flag_upd = ev | (cur & ~(clr & ~cond));
  endfunction

  // address match used by the error, write and read-clear decodes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // tap index above the counter top is clamped to the top bit
  function automatic logic [4:0] tap_idx(input logic [4:0] t);
    tap_idx = (t > `LFM_WD_TAP_MAX) ? `LFM_WD_TAP_MAX : t;
  endfunction

  // apb phases: one wait-free access after a setup that loads read data
  assign setup_ph = psel & ~penable;
  assign pready   = psel & penable;
  assign wr_done  = psel & penable & pwrite;
  assign rd_done  = psel & penable & ~pwrite;
  assign addr_ok  = hit(paddr, `LFM_OFS_STATUS_REG_ONE) | hit(paddr, `LFM_OFS_STATUS_REG_TWO) |
                    hit(paddr, `LFM_OFS_STATUS_REG_THREE) | hit(paddr, `LFM_OFS_SYSTEM_CONFIG_ONE) |
                    hit(paddr, `LFM_OFS_SYSTEM_CONFIG_TWO) | hit(paddr, `LFM_OFS_WDTAP) |
                    hit(paddr, `LFM_OFS_STATE);
  assign pslverr  = psel & penable & ~addr_ok;

  // read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `LFM_OFS_STATUS_REG_ONE: rd_mux[4*NCH-1:0] = status_reg_one_r;
      `LFM_OFS_STATUS_REG_TWO: rd_mux[3*NCH-1:0] = status_reg_two_r;
      `LFM_OFS_STATUS_REG_THREE: rd_mux[3:0] = status_reg_three_r;
      `LFM_OFS_SYSTEM_CONFIG_ONE: rd_mux[NCH+1:0] = system_config_one_r;
      `LFM_OFS_SYSTEM_CONFIG_TWO: rd_mux[3*NCH+2:0] = system_config_two_r;
      `LFM_OFS_WDTAP:   rd_mux[4:0] = watchdog_tap_select_r;
      `LFM_OFS_STATE:   rd_mux[NCH:0] = {standalone_mode, chan_held};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // standalone forces auto-restart with the shortest retry time
  assign ts_latch = standalone_mode ? '0 :
                    system_config_two_r[`LFM_CFG2_TS_LO +: NCH];
  assign hs_latch = standalone_mode ? '0 :
                    system_config_two_r[`LFM_CFG2_HS_LO +: NCH];
  assign ls_latch = standalone_mode ? '0 :
                    system_config_two_r[`LFM_CFG2_LS_LO +: NCH];
  assign pc_latch = ~standalone_mode & system_config_two_r[`LFM_CFG2_PC];
  assign ift_sel  = standalone_mode ? 2'b00 :
                    system_config_two_r[`LFM_CFG2_IFT_LO +: 2];
  // condition levels gathered in status bit order
  assign st1_src  = {loop_filter_high, ls_overcurrent, hs_overcurrent, short_cmp};
  assign st2_src  = {bootstrap_low, toff_min_hit, over_temp};

  // status_reg_one: short, high-side, low-side, loop filter pairs
  // short flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg_one_r <= `LFM_ST1_RST;
    end else begin
      for (int i = 0; i < 4*NCH; i++) begin
        status_reg_one_r[i] <= flag_upd(status_reg_one_r[i], st1_src[i], st1_src[i],
          rd_done & hit(paddr, `LFM_OFS_STATUS_REG_ONE));
      end
    end
  end

  // status_reg_two: thermal shutdown, min off-time, bootstrap pairs
  // thermal flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg_two_r <= `LFM_ST2_RST;
    end else begin
      for (int i = 0; i < 3*NCH; i++) begin
        status_reg_two_r[i] <= flag_upd(status_reg_two_r[i], st2_src[i], st2_src[i],
          rd_done & hit(paddr, `LFM_OFS_STATUS_REG_TWO));
      end
    end
  end

  // serial error from the framer or from watchdog expiry
  // serial error
  assign serial_err_evt = serial_frame_err | wd_expire;

  // status_reg_three: warning, power cycle, serial error, analog supply
  // power cycle flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg_three_r <= `LFM_ST3_RST;
    end else begin
      status_reg_three_r[`LFM_ST3_TW] <= flag_upd(status_reg_three_r[`LFM_ST3_TW],
        thermal_warn, thermal_warn, rd_done & hit(paddr, `LFM_OFS_STATUS_REG_THREE));
      status_reg_three_r[`LFM_ST3_PC] <= flag_upd(status_reg_three_r[`LFM_ST3_PC],
        power_cycle_evt, 1'b0, rd_done & hit(paddr, `LFM_OFS_STATUS_REG_THREE));
      status_reg_three_r[`LFM_ST3_SPE] <= flag_upd(status_reg_three_r[`LFM_ST3_SPE],
        serial_err_evt, 1'b0, rd_done & hit(paddr, `LFM_OFS_STATUS_REG_THREE));
      status_reg_three_r[`LFM_ST3_V5A] <= flag_upd(status_reg_three_r[`LFM_ST3_V5A],
        analog_supply_low, analog_supply_low, rd_done & hit(paddr, `LFM_OFS_STATUS_REG_THREE));
    end
  end

  // system_config_one: channel enables, watchdog enable, pin release strobe
  // watchdog enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_config_one_r <= `LFM_CFG1_RST;
    end else begin
      if (wr_done && hit(paddr, `LFM_OFS_SYSTEM_CONFIG_ONE)) begin
        system_config_one_r <= pwdata[NCH+1:0];
      end else begin
        system_config_one_r[`LFM_CFG1_FPREL] <= 1'b0; // release bit self-clears
      end
      for (int c = 0; c < NCH; c++) begin
        if (latch_go[c]) begin
          system_config_one_r[c] <= 1'b0;
        end
      end
    end
  end

  // enable written from zero to one restarts a latched channel whose current limit and thermal flags are clear
  // host restart
  assign en_rise = (wr_done && hit(paddr, `LFM_OFS_SYSTEM_CONFIG_ONE)) ?
                   (pwdata[NCH-1:0] & ~system_config_one_r[NCH-1:0]) : '0;

  // system_config_two and watchdog tap
  // latch selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_config_two_r   <= `LFM_CFG2_RST;
      watchdog_tap_select_r <= `LFM_WDTAP_RST;
    end else if (wr_done) begin
      if (hit(paddr, `LFM_OFS_SYSTEM_CONFIG_TWO)) begin
        system_config_two_r <= pwdata[3*NCH+2:0];
      end
      if (hit(paddr, `LFM_OFS_WDTAP)) begin
        watchdog_tap_select_r <= pwdata[4:0];
      end
    end
  end

  // watchdog expiry at the selected counter bit
  // tap expiry
  assign wd_expire = system_config_one_r[`LFM_CFG1_WDEN] & ~standalone_mode &
                     wd_cnt_r[tap_idx(watchdog_tap_select_r)];

  // watchdog counter restarted by every valid frame, stopped in standalone
  // enter standalone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r        <= '0;
      standalone_mode <= 1'b0;
    end else begin
      if (serial_frame_ok || !system_config_one_r[`LFM_CFG1_WDEN] || standalone_mode) begin
        wd_cnt_r <= '0;
      end else begin
        wd_cnt_r <= wd_cnt_r + `LFM_WD_WIDTH'(1);
      end
      if (wd_expire) begin
        standalone_mode <= 1'b1;
      end
    end
  end

  // independent protection path for each channel
  // per-channel state
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_chan
      // next-state decision
      always_comb begin
        chan_nxt[g] = chan_r[g];
        case (chan_r[g])
          LFM_OFF: begin
            if (system_config_one_r[g]) chan_nxt[g] = LFM_RUN;
          end
          LFM_RUN: begin
            if (!system_config_one_r[g]) chan_nxt[g] = LFM_OFF;
            else if (over_temp[g]) chan_nxt[g] = ts_latch[g] ? LFM_LATCH : LFM_THERM;
            else if (hs_overcurrent[g]) chan_nxt[g] = hs_latch[g] ? LFM_LATCH : LFM_RETRY;
            else if (ls_overcurrent[g]) chan_nxt[g] = ls_latch[g] ? LFM_LATCH : LFM_RETRY;
            else if (power_cycle_evt && pc_latch) chan_nxt[g] = LFM_LATCH;
          end
          LFM_RETRY: begin
            if (!system_config_one_r[g]) chan_nxt[g] = LFM_OFF;
            else if (retry_done[g]) chan_nxt[g] = LFM_RUN;
          end
          LFM_THERM: begin
            if (!system_config_one_r[g]) chan_nxt[g] = LFM_OFF;
            else if (temp_cooled[g]) chan_nxt[g] = LFM_RUN;
          end
          LFM_LATCH: begin
            if (en_rise[g] && !status_reg_one_r[NCH+g] && !status_reg_one_r[2*NCH+g]
                && !status_reg_two_r[g]) chan_nxt[g] = LFM_RUN;
          end
          default: chan_nxt[g] = LFM_OFF;
        endcase
      end

      assign latch_go[g]  = (chan_r[g] != LFM_LATCH) && (chan_nxt[g] == LFM_LATCH);
      assign retry_go[g]  = (chan_r[g] == LFM_RUN) && (chan_nxt[g] == LFM_RETRY);
      assign chan_held[g] = (chan_r[g] == LFM_RETRY) || (chan_r[g] == LFM_THERM) ||
                            (chan_r[g] == LFM_LATCH);

      // state, fault kind and switch controls, all registered
      // high-side response
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chan_r[g]          <= LFM_OFF;
          kind_hs_r[g]       <= 1'b0;
          hs_gate_en[g]      <= 1'b0;
          ls_gate_en[g]      <= 1'b0;
          comp_discharge[g]  <= 1'b1;
          comp_disconnect[g] <= 1'b0;
          soft_start[g]      <= 1'b0;
        end else begin
          chan_r[g] <= chan_nxt[g];
          if (chan_r[g] == LFM_RUN && chan_nxt[g] != LFM_RUN) begin
            kind_hs_r[g] <= hs_overcurrent[g] & ~over_temp[g];
          end
          hs_gate_en[g]      <= (chan_nxt[g] == LFM_RUN);
          ls_gate_en[g]      <= (chan_nxt[g] == LFM_RUN) ||
                                ((chan_nxt[g] == LFM_RETRY) &&
                                 ((chan_r[g] == LFM_RUN) ? (hs_overcurrent[g] & ~over_temp[g])
                                                         : kind_hs_r[g]));
          comp_discharge[g]  <= (chan_nxt[g] != LFM_RUN);
          comp_disconnect[g] <= (chan_nxt[g] == LFM_RUN) && toff_min_hit[g];
          soft_start[g]      <= (chan_r[g] != LFM_RUN) && (chan_nxt[g] == LFM_RUN);
        end
      end

      lfm_retry_timer #(
        .BASE_CYC (RETRY_CYC),
        .CNT_W    (24)
      ) u_retry (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (retry_go[g]),
        .sel     (ift_sel),
        .done    (retry_done[g])
      );
    end
  endgenerate

  // faults that pull the pin and faults that block its release
  // pin faults
  assign pin_event = (|hs_overcurrent) | (|ls_overcurrent) | (|over_temp) |
                     power_cycle_evt;
  assign any_fault = (|hs_overcurrent) | (|ls_overcurrent) | (|over_temp) | (|chan_held);

  // open-drain fault pin: set wins over release
  // guarded release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_low_r <= 1'b1; // power-up counts as a power cycle fault
    end else if (pin_event) begin
      pin_low_r <= 1'b1;
    end else if (system_config_one_r[`LFM_CFG1_FPREL] && !any_fault) begin
      pin_low_r <= 1'b0;
    end
  end

  assign fault_output_pin_o  = 1'b0;
  assign fault_output_pin_oe = pin_low_r;

endmodule // lfm_fault_mgr

// *** verification/lfm_host_model.sv ***
// apb host model that issues register transfers to the fault manager
`timescale 1ns/1ps
module lfm_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // bus idle until the first transfer
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // setup, access held until pready, release after that edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule // lfm_host_model

// *** verification/lfm_fault_mgr_properties.sv ***
// port level checks of the fault manager
`timescale 1ns/1ps
module lfm_properties #(
  parameter int unsigned NCH = 2
) (
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire logic [NCH-1:0] hs_overcurrent,
  input wire logic [NCH-1:0] ls_overcurrent,
  input wire logic [NCH-1:0] over_temp,
  input wire logic [NCH-1:0] toff_min_hit,
  input wire logic [NCH-1:0] hs_gate_en,
  input wire logic [NCH-1:0] ls_gate_en,
  input wire logic [NCH-1:0] comp_discharge,
  input wire logic [NCH-1:0] comp_disconnect,
  input wire logic [NCH-1:0] soft_start,
  input wire logic           standalone_mode,
  input wire logic           fault_output_pin_o,
  input wire logic           fault_output_pin_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; pready == (psel && penable); endproperty
  a_rdy: assert property (p_rdy) else $error("pready off access phase");
  property p_hs;
    hs_overcurrent[0] && hs_gate_en[0] |=> !hs_gate_en[0] && comp_discharge[0];
  endproperty
  a_hs: assert property (p_hs) else $error("high side not cut");
  property p_ls;
    ls_overcurrent[0] && !hs_overcurrent[0] && hs_gate_en[0]
      |=> !hs_gate_en[0] && !ls_gate_en[0] && comp_discharge[0];
  endproperty
  a_ls: assert property (p_ls) else $error("low side fault gates on");
  property p_ot; over_temp[1] && hs_gate_en[1] |=> !hs_gate_en[1] && !ls_gate_en[1];
  endproperty
  a_ot: assert property (p_ot) else $error("no thermal shutdown");
  property p_pin;
    (hs_overcurrent != 0 || ls_overcurrent != 0 || over_temp != 0)
      |=> fault_output_pin_oe && !fault_output_pin_o;
  endproperty
  a_pin: assert property (p_pin) else $error("fault pin not low");
  property p_tmin;
    1'b1 |=> comp_disconnect[0] == (hs_gate_en[0] && $past(toff_min_hit[0]));
  endproperty
  a_tmin: assert property (p_tmin) else $error("comp disconnect wrong");
  property p_sa; standalone_mode |=> standalone_mode; endproperty
  a_sa: assert property (p_sa) else $error("standalone dropped");
  property p_ss; soft_start[1] |=> !soft_start[1] [*2]; endproperty
  a_ss: assert property (p_ss) else $error("soft start not a pulse");
  c_err: cover property (pslverr);
  c_ss: cover property (soft_start[0]);
  c_sa: cover property ($rose(standalone_mode));
endmodule // lfm_properties
bind lfm_fault_mgr lfm_properties #(.NCH(NCH)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .hs_overcurrent(hs_overcurrent), .ls_overcurrent(ls_overcurrent),
  .over_temp(over_temp), .toff_min_hit(toff_min_hit), .hs_gate_en(hs_gate_en),
  .ls_gate_en(ls_gate_en), .comp_discharge(comp_discharge),
  .comp_disconnect(comp_disconnect), .soft_start(soft_start),
  .standalone_mode(standalone_mode), .fault_output_pin_o(fault_output_pin_o),
  .fault_output_pin_oe(fault_output_pin_oe));

// *** verification/led_driver_fault_manager_tb_top.sv ***
// self-checking bench of the fault manager
`timescale 1ns/1ps
`include "lfm_map.svh"
module led_driver_fault_manager_tb_top;
  localparam int RC = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  sc, hs, ls, tm, ot, tc, bl, lf, hs_g, ls_g, ss;
  logic        tw, asl, pc, ferr, sa, foe, feed;
  logic        fok = 1'b0;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  lfm_fault_mgr #(.NCH(2), .RETRY_CYC(RC)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .short_cmp(sc), .hs_overcurrent(hs), .ls_overcurrent(ls), .toff_min_hit(tm),
    .over_temp(ot), .temp_cooled(tc), .bootstrap_low(bl), .loop_filter_high(lf),
    .thermal_warn(tw), .analog_supply_low(asl), .power_cycle_evt(pc),
    .serial_frame_ok(fok), .serial_frame_err(ferr), .hs_gate_en(hs_g),
    .ls_gate_en(ls_g), .comp_discharge(), .comp_disconnect(), .soft_start(ss),
    .standalone_mode(sa), .fault_output_pin_o(), .fault_output_pin_oe(foe));
  lfm_host_model u_host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  // clock, serial frame feed and hang guard
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    fok <= feed && (cyc % 4 == 0);
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp, string nm);
    logic [31:0] q;
    logic        e;
    u_host.xfer(1'b0, a, 32'h0, q, e);
    chk(nm, exp, q);
    chk("slverr", (a > 8'h18), e);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic        e;
    u_host.xfer(1'b1, a, d, q, e);
  endtask
  // status word expected from current and still-sticky earlier inputs
  function automatic logic [31:0] st_exp(int k, logic [11:0] c, logic [11:0] p);
    logic [11:0] v;
    v = c | (p & 12'h3ff);
    if (k == 0) return {24'h0, v[7:6], 4'h0, v[9:8]};
    if (k == 1) return {26'h0, v[5:4], v[3:2], 2'b00};
    return {28'h0, v[0], v[10], v[11], v[1]};
  endfunction
  initial begin
    logic [11:0] r, p;
    int          n;
    logic        oth;
    logic        lsv;
    pclk = 1'b0;
    presetn = 1'b0;
    feed = 1'b1;
    {sc, hs, ls, tm, ot, tc, bl, lf} = '0;
    {tw, asl, pc, ferr} = '0;
    void'($urandom(11));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("pin_reset", 1, foe);
    rd(`LFM_OFS_STATUS_REG_THREE, 32'h2, "st3_reset");
    rd(`LFM_OFS_SYSTEM_CONFIG_ONE, 32'h4, "cfg1_reset");
    rd(`LFM_OFS_WDTAP, 32'h18, "wdtap_reset");
    rd(`LFM_OFS_STATUS_REG_THREE, 32'h0, "st3_cleared");
    rd(8'h1c, 32'h0, "unmapped");
    // random diagnostic levels and events, two quiet rounds at the end
    p = '0;
    for (int i = 0; i < 7; i++) begin
      r = (i > 4) ? 12'h0 : 12'($urandom);
      {sc, lf, bl, tm, tw, asl} <= r[9:0];
      ferr <= r[10];
      pc <= r[11];
      @(posedge pclk);
      {ferr, pc} <= 2'b00;
      @(posedge pclk);
      for (int k = 0; k < 3; k++)
        rd(8'(4 * k), st_exp(k, r, p), "status");
      p = r;
    end
    // latch-off on a high side fault of channel 0
    wr(`LFM_OFS_SYSTEM_CONFIG_TWO, 32'h4);
    wr(`LFM_OFS_SYSTEM_CONFIG_ONE, 32'h7);
    hs[0] <= 1'b1;
    @(posedge pclk);
    hs[0] <= 1'b0;
    repeat (RC * 4) @(posedge pclk);
    chk("ch0_gates", 0, {hs_g[0], ls_g[0]});
    rd(`LFM_OFS_STATE, 32'h1, "state_latched");
    rd(`LFM_OFS_SYSTEM_CONFIG_ONE, 32'h6, "cfg1_latched");
    wr(`LFM_OFS_SYSTEM_CONFIG_ONE, 32'he);
    @(posedge pclk);
    chk("pin_held", 1, foe);
    rd(`LFM_OFS_STATUS_REG_ONE, 32'h4, "st1_hs");
    wr(`LFM_OFS_SYSTEM_CONFIG_ONE, 32'h7);
    rd(`LFM_OFS_STATE, 32'h0, "state_restart");
    wr(`LFM_OFS_SYSTEM_CONFIG_ONE, 32'hf);
    @(posedge pclk);
    chk("pin_free", 0, foe);
    // thermal auto-restart waits for cooling
    ot[1] <= 1'b1;
    @(posedge pclk);
    ot[1] <= 1'b0;
    oth = 1'b0;
    repeat (30) begin
      @(posedge pclk);
      oth |= ss[1];
    end
    chk("early_restart", 0, oth);
    tc[1] <= 1'b1;
    repeat (4) begin
      @(posedge pclk);
      oth |= ss[1];
    end
    chk("thermal_restart", 1, oth);
    tc[1] <= 1'b0;
    rd(`LFM_OFS_STATUS_REG_TWO, 32'h2, "st2_thermal");
    // current limit retry for every timer select
    for (int s = 0; s < 4; s++) begin
      wr(`LFM_OFS_SYSTEM_CONFIG_TWO, 32'(s) << 6);
      repeat ($urandom % 8) @(posedge pclk);
      if (s > 1) hs[s%2] <= 1'b1;
      else ls[s%2] <= 1'b1;
      @(posedge pclk);
      {hs, ls} <= 4'h0;
      n = 0;
      oth = 1'b0;
      while (ss[s%2] !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
        oth |= ss[1-s%2];
        if (n == 4) lsv = ls_g[s%2];
      end
      chk("retry_time", 1, n >= (RC << s) && n <= (RC << s) + 4);
      chk("other_chan", 0, oth);
      chk("ls_in_retry", s > 1, lsv);
    end
    // power-cycle latch of both channels, restart after the flags are read clear
    wr(`LFM_OFS_SYSTEM_CONFIG_TWO, 32'h100);
    pc <= 1'b1;
    @(posedge pclk);
    pc <= 1'b0;
    rd(`LFM_OFS_STATE, 32'h3, "state_pc");
    rd(`LFM_OFS_STATUS_REG_ONE, 32'h3c, "st1_limits");
    rd(`LFM_OFS_STATUS_REG_THREE, 32'h2, "st3_pc");
    wr(`LFM_OFS_SYSTEM_CONFIG_ONE, 32'h7);
    rd(`LFM_OFS_STATE, 32'h0, "state_pc_restart");
    tm <= 2'b01;
    repeat (3) @(posedge pclk);
    tm <= 2'b00;
    // watchdog with a short tap
    wr(`LFM_OFS_WDTAP, 32'h3);
    rd(`LFM_OFS_WDTAP, 32'h3, "wdtap");
    repeat (40) @(posedge pclk);
    chk("fed", 0, sa);
    feed <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("standalone", 1, sa);
    rd(`LFM_OFS_STATUS_REG_THREE, 32'h4, "st3_wd");
    summarize();
  end
endmodule // led_driver_fault_manager_tb_top
